// >>> inc/bst_regs.vh
`ifndef BST_REGS_VH
`define BST_REGS_VH

// ==========================================================
// Scan register layout
`define BST_IR_WIDTH      8
`define BST_IR_CAPTURE    8'h81
`define BST_IR_BYPASS     8'hff
`define BST_DR_WIDTH      8

// ==========================================================
// Output buffer
`define BST_FIFO_DEPTH    16
`define BST_FIFO_AW       4

// ==========================================================
// One-hot TAP states
`define BST_ST_RESET      16'h0001
`define BST_ST_IDLE       16'h0002
`define BST_ST_SELDR      16'h0004
`define BST_ST_CAPDR      16'h0008
`define BST_ST_SHDR       16'h0010
`define BST_ST_EX1DR      16'h0020
`define BST_ST_PAUSEDR    16'h0040
`define BST_ST_EX2DR      16'h0080
`define BST_ST_UPDR       16'h0100
`define BST_ST_SELIR      16'h0200
`define BST_ST_CAPIR      16'h0400
`define BST_ST_SHIR       16'h0800
`define BST_ST_EX1IR      16'h1000
`define BST_ST_PAUSEIR    16'h2000
`define BST_ST_EX2IR      16'h4000
`define BST_ST_UPIR       16'h8000

`endif

// >>> design/bst_tap.v
`timescale 1ns/100ps
// Functional notes
// - TDI, TMS and function inputs are sampled on rising TCK only.
// - TDO and function outputs change only on falling TCK.
// - 8-bit instruction register captures 10000001 leaving Capture-IR.
// - TDO starts driving on falling edge in Shift-IR or Shift-DR.
// - One instruction bit per rising edge; last bit shifts entering Exit1-IR.
// - TDO returns to high impedance on falling edge in Exit1 states.
// - Active instruction replaced on falling edge in Update-IR; in Test-Logic-Reset it is forced to bypass.
// - All-ones instruction selects bypass after update.
// - Bypass register loads 0 on rising edge leaving Capture-DR.
// - Selected data register updates on falling edge in Update-DR.
`include "bst_regs.vh"

// ==========================================================
// Buffer with registered head word
module bst_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             rst,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output reg              outValid,
  input  wire             outReady,
  output reg  [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr;
  reg [AW-1:0]    rdPtr;
  reg [AW:0]      count;
  wire            push;
  wire            load;
  wire            pop;

  assign inReady = (count != DEPTH[AW:0]);
  assign push    = inValid & inReady;
  assign pop     = outValid & outReady;
  assign load    = (~outValid | pop) & (count != {(AW+1){1'b0}});

  always @(posedge mclk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + 1'b1;
      if (load)
      begin
        outData  <= mem[rdPtr];
        rdPtr    <= rdPtr + 1'b1;
        outValid <= 1'b1;
      end
      else if (pop)
        outValid <= 1'b0;
      if (push && !load)
        count <= count + 1'b1;
      else if (load && !push)
        count <= count - 1'b1;
    end
  end
endmodule // bst_fifo

// ==========================================================
// Test access port, sampled on the system clock
module bst_tap (
  // Clock and reset
  input  wire                     mclk,
  input  wire                     rst,
  // Scan pins
  input  wire                     tck,
  input  wire                     tms,
  input  wire                     tdi,
  output reg                      tdo,
  output reg                      tdoOe_n,
  // Function pins
  input  wire [`BST_DR_WIDTH-1:0] pinIn,
  output reg  [`BST_DR_WIDTH-1:0] pinOut,
  // Status
  output reg                      bypassSel,
  output reg                      wordPending,
  // Updated words toward user logic
  output wire                     wordValid,
  input  wire                     wordReady,
  output wire [`BST_DR_WIDTH-1:0] wordData
);
  localparam ST_RESET   = `BST_ST_RESET;
  localparam ST_IDLE    = `BST_ST_IDLE;
  localparam ST_SELDR   = `BST_ST_SELDR;
  localparam ST_CAPDR   = `BST_ST_CAPDR;
  localparam ST_SHDR    = `BST_ST_SHDR;
  localparam ST_EX1DR   = `BST_ST_EX1DR;
  localparam ST_PAUSEDR = `BST_ST_PAUSEDR;
  localparam ST_EX2DR   = `BST_ST_EX2DR;
  localparam ST_UPDR    = `BST_ST_UPDR;
  localparam ST_SELIR   = `BST_ST_SELIR;
  localparam ST_CAPIR   = `BST_ST_CAPIR;
  localparam ST_SHIR    = `BST_ST_SHIR;
  localparam ST_EX1IR   = `BST_ST_EX1IR;
  localparam ST_PAUSEIR = `BST_ST_PAUSEIR;
  localparam ST_EX2IR   = `BST_ST_EX2IR;
  localparam ST_UPIR    = `BST_ST_UPIR;

  // ==========================================================
  // Pin synchronisers
  reg  [2:0]               syncA;
  reg  [2:0]               syncB;
  reg  [`BST_DR_WIDTH-1:0] pinA;
  reg  [`BST_DR_WIDTH-1:0] pinB;
  reg                      tckPrev;
  wire                     tckS;
  wire                     tmsS;
  wire                     tdiS;
  wire                     tckRise;
  wire                     tckFall;

  assign tckS    = syncB[2];
  assign tmsS    = syncB[1];
  assign tdiS    = syncB[0];
  assign tckRise = tckS & ~tckPrev;
  assign tckFall = ~tckS & tckPrev;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      syncA   <= 3'h0;
      syncB   <= 3'h0;
      pinA    <= {`BST_DR_WIDTH{1'b0}};
      pinB    <= {`BST_DR_WIDTH{1'b0}};
      tckPrev <= 1'b0;
    end
    else
    begin
      syncA   <= {tck, tms, tdi};
      syncB   <= syncA;
      pinA    <= pinIn;
      pinB    <= pinA;
      tckPrev <= tckS;
    end
  end

  // ==========================================================
  // Controller state graph
  reg  [15:0] state;
  reg  [15:0] next_state;

  always @*
  begin
    case (state)
      ST_RESET:   next_state = tmsS ? ST_RESET : ST_IDLE;
      ST_IDLE:    next_state = tmsS ? ST_SELDR : ST_IDLE;
      ST_SELDR:   next_state = tmsS ? ST_SELIR : ST_CAPDR;
      ST_CAPDR:   next_state = tmsS ? ST_EX1DR : ST_SHDR;
      ST_SHDR:    next_state = tmsS ? ST_EX1DR : ST_SHDR;
      ST_EX1DR:   next_state = tmsS ? ST_UPDR : ST_PAUSEDR;
      ST_PAUSEDR: next_state = tmsS ? ST_EX2DR : ST_PAUSEDR;
      ST_EX2DR:   next_state = tmsS ? ST_UPDR : ST_SHDR;
      ST_UPDR:    next_state = tmsS ? ST_SELDR : ST_IDLE;
      ST_SELIR:   next_state = tmsS ? ST_RESET : ST_CAPIR;
      ST_CAPIR:   next_state = tmsS ? ST_EX1IR : ST_SHIR;
      ST_SHIR:    next_state = tmsS ? ST_EX1IR : ST_SHIR;
      ST_EX1IR:   next_state = tmsS ? ST_UPIR : ST_PAUSEIR;
      ST_PAUSEIR: next_state = tmsS ? ST_EX2IR : ST_PAUSEIR;
      ST_EX2IR:   next_state = tmsS ? ST_UPIR : ST_SHIR;
      ST_UPIR:    next_state = tmsS ? ST_SELDR : ST_IDLE;
      default:    next_state = ST_RESET;
    endcase
  end

  // ==========================================================
  // Rising-edge work: state, capture and shift
  reg  [`BST_IR_WIDTH-1:0] irShift;
  reg  [`BST_DR_WIDTH-1:0] drShift;
  reg                      bypassBit;
  wire                     fifoReady;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state     <= ST_RESET;
      irShift   <= `BST_IR_CAPTURE;
      drShift   <= {`BST_DR_WIDTH{1'b0}};
      bypassBit <= 1'b0;
    end
    else if (tckRise)
    begin
      state <= next_state;
      if (state == ST_CAPIR)
        irShift <= `BST_IR_CAPTURE;
      else if (state == ST_SHIR)
        irShift <= {tdiS, irShift[`BST_IR_WIDTH-1:1]};
      if (state == ST_CAPDR)
      begin
        bypassBit <= 1'b0;
        drShift   <= pinB;
      end
      else if (state == ST_SHDR)
      begin
        bypassBit <= tdiS;
        drShift   <= {tdiS, drShift[`BST_DR_WIDTH-1:1]};
      end
    end
  end

  // ==========================================================
  // Falling-edge work: TDO, instruction and data update
  reg  [`BST_DR_WIDTH-1:0] pendWord;

  // A word updated while the buffer is full waits here; a later update
  // overwrites it, since the scan clock cannot be held back.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tdo         <= 1'b1;
      tdoOe_n     <= 1'b1;
      bypassSel   <= 1'b1;
      pinOut      <= {`BST_DR_WIDTH{1'b0}};
      pendWord    <= {`BST_DR_WIDTH{1'b0}};
      wordPending <= 1'b0;
    end
    else
    begin
      if (wordPending && fifoReady)
        wordPending <= 1'b0;
      if (tckFall)
      begin
        if (state == ST_SHIR)
        begin
          tdo     <= irShift[0];
          tdoOe_n <= 1'b0;
        end
        else if (state == ST_SHDR)
        begin
          tdo     <= bypassSel ? bypassBit : drShift[0];
          tdoOe_n <= 1'b0;
        end
        else
          tdoOe_n <= 1'b1;
        if (state == ST_RESET)
          bypassSel <= 1'b1;
        else if (state == ST_UPIR)
          bypassSel <= (irShift == `BST_IR_BYPASS);
        if (state == ST_UPDR && !bypassSel)
        begin
          pinOut      <= drShift;
          pendWord    <= drShift;
          wordPending <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Updated-word buffer
  bst_fifo #(
    .WIDTH (`BST_DR_WIDTH),
    .DEPTH (`BST_FIFO_DEPTH),
    .AW    (`BST_FIFO_AW)
  ) uFifo (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (wordPending),
    .inReady  (fifoReady),
    .inData   (pendWord),
    .outValid (wordValid),
    .outReady (wordReady),
    .outData  (wordData)
  );
endmodule // bst_tap

// >>> bench/bst_tap_checker.sv
`timescale 1ns/100ps
module bst_tap_checker (
  // Clock and reset
  input wire       mclk,
  input wire       rst,
  // Scan pins
  input wire       tck,
  input wire       tdo,
  input wire       tdoOe_n,
  // Function and status
  input wire [7:0] pinOut,
  input wire       bypassSel,
  input wire       wordPending,
  // User stream
  input wire       wordValid,
  input wire       wordReady,
  input wire [7:0] wordData
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========
  // Scan side: sync delay is short of half a tck period, so changes land in the low phase
  tdo_fall_only_a: assert property ($changed(tdo) |-> !$past(tck))
    else $error("tdo moved in tck high phase");
  oe_fall_only_a: assert property ($changed(tdoOe_n) |-> !$past(tck))
    else $error("tdo enable moved in tck high phase");
  pins_fall_only_a: assert property ($changed(pinOut) |-> !$past(tck))
    else $error("pinOut moved in tck high phase");
  tdo_idle_a: assert property (tdoOe_n && $past(tdoOe_n) |-> $stable(tdo))
    else $error("tdo moved while disabled");
  instr_hold_a: assert property (!tdoOe_n |-> $stable(bypassSel))
    else $error("instruction changed during shift");
  bypass_pins_a: assert property (bypassSel && $past(bypassSel) |-> $stable(pinOut))
    else $error("pinOut changed under bypass");
  // ==========
  // Stream side
  word_update_a: assert property ($rose(wordPending) |-> tdoOe_n)
    else $error("word raised outside update");
  word_hold_a: assert property (wordValid && !wordReady |=> wordValid && $stable(wordData))
    else $error("head word dropped before taken");
  word_arrive_a: assert property ($rose(wordPending) && !wordValid |-> ##[1:3] wordValid)
    else $error("word did not reach empty buffer head");
  cover property ($fell(tdoOe_n));
  cover property ($rose(bypassSel));
  cover property (wordPending && wordValid && !wordReady);
endmodule // bst_tap_checker

bind bst_tap bst_tap_checker chk_i (.mclk(mclk), .rst(rst), .tck(tck), .tdo(tdo), .tdoOe_n(tdoOe_n),
  .pinOut(pinOut), .bypassSel(bypassSel), .wordPending(wordPending), .wordValid(wordValid),
  .wordReady(wordReady), .wordData(wordData));

// >>> bench/bst_ctl_model.sv
`timescale 1ns/100ps
module bst_ctl_model (
  // Clock
  input  wire mclk,
  // Scan pins
  output reg  tck,
  output reg  tms,
  output reg  tdi,
  input  wire tdo,
  input  wire tdoOe_n
);
  // Tck stands still between frames; tms and tdi rest high as if pulled up
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // ==========
  // One tck cycle, four mclk per phase; tdo read late in the high phase, well settled
  task step(input logic m, input logic d, output logic q, output logic oe);
    begin
      @(posedge mclk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge mclk);
      tck <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      // A released line carries no stale value: show the inverse
      q = tdoOe_n ? ~tdo : tdo;
      oe = tdoOe_n;
    end
  endtask
endmodule // bst_ctl_model

// >>> bench/tb_top.sv
`timescale 1ns/100ps
`include "bst_regs.vh"
module tb_top;
  reg        mclk, rst, wordReady, t, oe, bs;
  reg  [7:0] pinIn, got, v, oes, pv;
  reg  [7:0] q[$];
  wire       tck, tms, tdi, tdo, tdoOe_n, bypassSel, wordPending, wordValid;
  wire [7:0] pinOut, wordData;
  integer    error_cnt, cmp_count, seed, i, k;

  bst_ctl_model m (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe_n(tdoOe_n));
  bst_tap uut (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe_n(tdoOe_n),
    .pinIn(pinIn), .pinOut(pinOut), .bypassSel(bypassSel), .wordPending(wordPending),
    .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData));

  always #10 mclk = ~mclk;

  task chk(input [7:0] a, input [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (a !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("ERROR at %0t: got %h expected %h", $time, a, e);
      end
    end
  endtask
  // Bypass shows the captured 0 first, then each bit one shift late
  function [7:0] bypass_out(input [7:0] din, input integer n);
    begin
      bypass_out = (din << 1) & ~(8'hff << n);
    end
  endfunction
  // ==========
  // Full scan from idle back to idle, bits LSB first
  task scan(input logic ir, input [7:0] din, input integer n, output [7:0] dout);
    begin
      dout = 8'h00;
      oes = 8'h00;
      pv = pinOut;
      bs = bypassSel;
      m.step(1'b1, 1'b1, t, oe);
      if (ir)
        m.step(1'b1, 1'b1, t, oe);
      m.step(1'b0, 1'b1, t, oe);
      m.step(1'b0, 1'b1, t, oe);
      for (k = 0; k < n; k = k + 1)
        m.step(k == n - 1, din[k], dout[k], oes[k]);
      m.step(1'b1, 1'b1, t, oe);
      chk(oes, 8'h00);
      chk({7'h0, oe}, 8'h01);
      chk(pinOut, pv);
      chk({7'h0, bypassSel}, {7'h0, bs});
      m.step(1'b0, 1'b1, t, oe);
    end
  endtask

  task print_verdict;
    begin
      $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ==========
  // Main sequence
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    wordReady = 1'b0;
    pinIn = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    seed = 32'he645;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(negedge mclk);
    chk({tdo, tdoOe_n, bypassSel, wordValid, wordPending, 3'h0}, 8'he0);
    chk(pinOut, 8'h00);
    m.step(1'b0, 1'b1, t, oe);
    scan(1'b1, `BST_IR_BYPASS, 8, v);
    chk(v, `BST_IR_CAPTURE);
    chk({7'h0, bypassSel}, 8'h01);
    scan(1'b0, 8'h05, 3, v);
    chk(v, 8'h02);
    scan(1'b1, {1'b0, 7'($random(seed))}, 8, v);
    chk(v, `BST_IR_CAPTURE);
    chk({7'h0, bypassSel}, 8'h00);
    // Overfill: 17 fit, the last waits in the pending stage
    for (i = 0; i < 18; i = i + 1)
    begin
      @(posedge mclk);
      pinIn <= 8'($random(seed));
      v = 8'($random(seed));
      scan(1'b0, v, 8, got);
      chk(got, pinIn);
      chk(pinOut, v);
      q.push_back(v);
    end
    chk({7'h0, wordPending}, 8'h01);
    for (i = 0; i < 500 && q.size() > 0; i = i + 1)
    begin
      @(negedge mclk);
      if (wordValid === 1'b1 && wordReady === 1'b1)
        chk(wordData, q.pop_front());
      @(posedge mclk);
      wordReady <= 1'($random(seed));
    end
    if (q.size() != 0)
      chk(8'h00, 8'h01);
    repeat (3) @(negedge mclk);
    chk({6'h0, wordValid, wordPending}, 8'h00);
    scan(1'b1, `BST_IR_BYPASS, 8, v);
    chk({7'h0, bypassSel}, 8'h01);
    v = 8'($random(seed));
    i = 1 + {$random(seed)} % 8;
    scan(1'b0, v, i, got);
    chk(got, bypass_out(v, i));
    chk(pinOut, pv);
    scan(1'b1, 8'h00, 8, v);
    chk(v, `BST_IR_CAPTURE);
    chk({7'h0, bypassSel}, 8'h00);
    for (i = 0; i < 5; i = i + 1)
      m.step(1'b1, 1'b1, t, oe);
    chk({7'h0, bypassSel}, 8'h01);
    print_verdict;
  end
endmodule // tb_top
